/* logic/rtd_decoder.sv */
// Request framing, flag decoding and first command group of the tag.
// Assumes bit-level decode and line coding outside; inputs are synchronous.
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rtd_decoder (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Request bit stream
  input  wire logic              rx_sof,
  input  wire logic              rx_bit_valid,
  input  wire logic              rx_bit,
  input  wire logic              rx_eof,
  input  wire logic              rx_err,
  // Selection made by the select command handler
  input  wire logic              selected_set,
  // Response item stream
  output logic                   tx_valid,
  output rtd_pkg::rtd_kind_t     tx_kind,
  output logic                   tx_bit,
  output logic                   tx_dual,
  input  wire logic              tx_ready,
  // Memory read port
  output logic                   nvm_rd,
  output logic                   nvm_sel,
  input  wire logic [63:0]       nvm_rdata,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import rtd_pkg::*;

  // Identifier and animal number, loaded once after reset.
  logic [2:0]        boot_ff;
  logic              nvm_rd_ff, nvm_sel_ff;
  logic [UID_W-1:0]  uid_ff;
  logic [AID_W-1:0]  aid_ff;
  logic [1:0]        ctrl_ff;
  wire boot_done = (boot_ff == BOOT_DONE);
  wire rx_go     = boot_done & ctrl_ff[CTRL_EN_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_ff    <= 3'h0;
      nvm_rd_ff  <= 1'b0;
      nvm_sel_ff <= NVM_SEL_UID;
      uid_ff     <= '0;
      aid_ff     <= '0;
    end else begin
      if (!boot_done) boot_ff <= boot_ff + 3'h1;
      nvm_rd_ff  <= (boot_ff == 3'h0) | (boot_ff == 3'h1);
      nvm_sel_ff <= (boot_ff == 3'h1) ? NVM_SEL_ANIMAL : NVM_SEL_UID;
      if (boot_ff == 3'h2) uid_ff <= nvm_rdata[UID_W-1:0];
      if (boot_ff == 3'h3) aid_ff <= nvm_rdata;
    end
  end

  // Request capture.
  logic              in_frame_ff, bad_ff;
  logic [7:0]        cnt_ff;
  logic [HDR_W-1:0]  hdr_ff;
  logic [MLEN_W-1:0] mlen_ff;
  logic [UID_W-1:0]  data_ff;
  logic [CRC_W-1:0]  crc_rx_ff;
  logic [15:0]       crc_req;

  wire [5:0] cmd      = hdr_ff[HDR_W-1:CMD_LSB];
  wire       f_ext    = hdr_ff[FLG_PROTOCOL_EXT];
  wire       f_inv    = hdr_ff[FLG_INVENTORY];
  wire       f_crc    = hdr_ff[FLG_RESP_CRC];
  wire       f_sel    = hdr_ff[FLG_SELECT];
  wire       f_adr    = hdr_ff[FLG_ADDRESS];
  wire       is_inv   = (cmd == CMD_INVENTORY) | (cmd == CMD_INV_ANIMAL);
  wire       is_quiet = (cmd == CMD_GO_QUIET);
  wire       is_read  = (cmd == CMD_READ_ID);
  wire [7:0] data_off = is_inv ? OFS_MASK : OFS_CMD_END;
  wire [7:0] data_len = is_inv ? {2'h0, mlen_ff} :
                        (is_quiet & f_adr) ? UID_BITS : 8'h00;
  wire [7:0] data_end = data_off + data_len;
  wire [7:0] crc_end  = data_end + REQ_CRC_BITS;
  wire [7:0] data_idx = cnt_ff - data_off;
  wire       rx_take  = rx_go & rx_bit_valid & in_frame_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame_ff <= 1'b0;
      cnt_ff      <= 8'h00;
      bad_ff      <= 1'b0;
    end else if (rx_go) begin
      if (rx_sof) begin
        in_frame_ff <= 1'b1;
        cnt_ff      <= 8'h00;
        bad_ff      <= 1'b0;
      end else if (rx_eof) begin
        in_frame_ff <= 1'b0;
      end else if (rx_take & (cnt_ff != 8'hFF)) begin
        cnt_ff <= cnt_ff + 8'h01;
      end
      if (in_frame_ff & rx_err) bad_ff <= 1'b1;
    end
  end

  // Every field is stored bit by bit as it arrives, least significant first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_ff    <= '0;
      mlen_ff   <= '0;
      data_ff   <= '0;
      crc_rx_ff <= '0;
    end else if (rx_take) begin
      if (cnt_ff < OFS_CMD_END) begin
        hdr_ff[cnt_ff[3:0]] <= rx_bit;
      end else if (is_inv & (cnt_ff < OFS_MASK)) begin
        mlen_ff[3'(cnt_ff - OFS_CMD_END)] <= rx_bit;
      end else if (cnt_ff < data_end) begin
        if (data_idx < UID_BITS) data_ff[data_idx[5:0]] <= rx_bit;
      end else if (cnt_ff < crc_end) begin
        crc_rx_ff[4'(cnt_ff - data_end)] <= rx_bit;
      end
    end
  end

  rtd_crc16 u_crc_req (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (rx_go & rx_sof),
    .en    (rx_take & (cnt_ff < data_end)),
    .din   (rx_bit),
    .crc   (crc_req)
  );

  // End-of-frame evaluation.
  rtd_state_t state_ff;
  logic       round_ff;
  logic [3:0] slot_cnt_ff, slot_val_ff;
  rtd_phase_t phase_ff;

  wire req_crc   = ctrl_ff[CTRL_REQ_CRC_BIT];
  wire [7:0] exp_len = req_crc ? crc_end : data_end;
  wire frame_ok  = (cnt_ff == exp_len) & (cnt_ff >= OFS_CMD_END) & !bad_ff
                 & (!req_crc | (crc_rx_ff == crc_req))
                 & !f_ext;
  wire frame_end = rx_go & rx_eof & in_frame_ff;
  wire bare_eof  = rx_go & rx_eof & !in_frame_ff;
  wire [UID_W-1:0] low_ones = !is_inv ? '1
                            : UID_W'((49'h1 << mlen_ff) - 49'h1);
  wire uid_match = ((uid_ff ^ data_ff) & low_ones) == '0;
  wire one_slot  = f_adr;
  wire [5:0] mlen_max = one_slot ? MLEN_MAX_1SLOT : MLEN_MAX_16SLOT;
  wire [3:0] slot_of = 4'(uid_ff >> mlen_ff);

  // Address and select decode when the inventory flag is clear.
  wire addr_hit = f_adr ? (!f_sel & uid_match) :
                  f_sel ? (state_ff == ST_SELECTED) :
                          (state_ff == ST_READY);
  wire quiet_gate = (state_ff != ST_QUIET) | f_adr;

  // Inventory: any fault leaves the tag silent, no error reply.
  wire inv_ok = is_inv & frame_ok & f_inv & !f_sel
              & (state_ff == ST_READY) & (mlen_ff <= mlen_max)
              & uid_match;
  wire quiet_ok = is_quiet & frame_ok & !f_inv & addr_hit & quiet_gate;
  wire read_part = is_read & quiet_gate & (cnt_ff >= OFS_CMD_END)
                 & ((state_ff == ST_READY) | f_adr);
  wire read_good = frame_ok & !f_inv & !f_sel & !f_adr;
  wire rsp_now   = (inv_ok & (one_slot | (slot_of == 4'h0)))
                 | read_part;
  wire slot_hit  = bare_eof & round_ff & (slot_cnt_ff + 4'h1 == slot_val_ff);
  wire tx_idle   = (phase_ff == PH_IDLE);
  wire start     = tx_idle & ((frame_end & rsp_now) | slot_hit);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_READY;
    end else if (selected_set) begin
      state_ff <= ST_SELECTED;
    end else if (frame_end & quiet_ok) begin
      state_ff <= ST_QUIET;
    end else if (frame_end & read_part & read_good) begin
      state_ff <= ST_READY;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      round_ff    <= 1'b0;
      slot_cnt_ff <= 4'h0;
      slot_val_ff <= 4'h0;
    end else if (rx_go & rx_sof) begin
      round_ff <= 1'b0;
    end else if (frame_end & inv_ok & !one_slot) begin
      round_ff    <= 1'b1;
      slot_cnt_ff <= 4'h0;
      slot_val_ff <= slot_of;
    end else if (bare_eof & round_ff) begin
      slot_cnt_ff <= slot_cnt_ff + 4'h1;
      if (slot_cnt_ff == LAST_SLOT) round_ff <= 1'b0;
    end
  end

  // Reply parameters are kept for later slots of the same round.
  logic [5:0] rsp_from_ff;
  logic       rsp_aid_ff, rsp_err_ff, rsp_crc_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_from_ff <= 6'h00;
      rsp_aid_ff  <= 1'b0;
      rsp_err_ff  <= 1'b0;
      rsp_crc_ff  <= 1'b0;
    end else if (frame_end & tx_idle & (inv_ok | read_part)) begin
      rsp_from_ff <= is_inv ? mlen_ff : 6'h00;
      rsp_aid_ff  <= (cmd == CMD_INV_ANIMAL);
      rsp_err_ff  <= is_read & !read_good;
      rsp_crc_ff  <= f_crc;
    end
  end

  // Response sequencer.
  logic [6:0]  idx_ff;
  logic        tx_valid_ff, tx_bit_ff, tx_dual_ff;
  rtd_kind_t   tx_kind_ff;
  logic [15:0] crc_rsp;
  rtd_phase_t  step_phase, nxt_phase, tail_phase;
  logic [6:0]  step_idx, nxt_idx;
  logic        nxt_bit;

  wire hs       = tx_valid_ff & tx_ready;
  wire load     = start | hs;
  wire from_end = (rsp_from_ff == UID_BITS[5:0]);

  always_comb begin
    tail_phase = rsp_crc_ff ? PH_CRC : PH_EOF;
    step_phase = phase_ff;
    step_idx   = idx_ff + 7'h01;
    unique case (phase_ff)
      PH_IDLE: step_idx = idx_ff;
      PH_SOF: begin
        step_phase = PH_FLAG;
        step_idx   = 7'h00;
      end
      PH_FLAG: begin
        step_idx = 7'h00;
        if (rsp_err_ff) begin
          step_phase = PH_CODE;
        end else if (!from_end) begin
          step_phase = PH_UID;
          step_idx   = {1'b0, rsp_from_ff};
        end else begin
          step_phase = rsp_aid_ff ? PH_ANIMAL : tail_phase;
        end
      end
      PH_UID: if (idx_ff == LAST_UID_IDX) begin
        step_phase = rsp_aid_ff ? PH_ANIMAL : tail_phase;
        step_idx   = 7'h00;
      end
      PH_ANIMAL: if (idx_ff == LAST_AID_IDX) begin
        step_phase = tail_phase;
        step_idx   = 7'h00;
      end
      PH_CODE: if (idx_ff == LAST_CODE_IDX) begin
        step_phase = tail_phase;
        step_idx   = 7'h00;
      end
      PH_CRC: if (idx_ff == LAST_CRC_IDX) begin
        step_phase = PH_EOF;
        step_idx   = 7'h00;
      end
      PH_EOF: begin
        step_phase = PH_IDLE;
        step_idx   = 7'h00;
      end
    endcase
  end

  assign nxt_phase = start ? PH_SOF : hs ? step_phase : phase_ff;
  assign nxt_idx   = start ? 7'h00 : hs ? step_idx : idx_ff;

  // The CRC unit is fed as each bit is loaded, so it is complete before
  // the first CRC bit is loaded.
  always_comb begin
    unique case (nxt_phase)
      PH_FLAG:   nxt_bit = rsp_err_ff;
      PH_UID:    nxt_bit = uid_ff[nxt_idx[5:0]];
      PH_ANIMAL: nxt_bit = aid_ff[nxt_idx[5:0]];
      PH_CODE:   nxt_bit = ERR_CODE[nxt_idx[1:0]];
      PH_CRC:    nxt_bit = crc_rsp[nxt_idx[3:0]];
      default:   nxt_bit = 1'b0;
    endcase
  end

  wire nxt_data = (nxt_phase == PH_FLAG) | (nxt_phase == PH_UID)
                | (nxt_phase == PH_ANIMAL) | (nxt_phase == PH_CODE);

  rtd_crc16 u_crc_rsp (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (start),
    .en    (load & nxt_data),
    .din   (nxt_bit),
    .crc   (crc_rsp)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff    <= PH_IDLE;
      idx_ff      <= 7'h00;
      tx_valid_ff <= 1'b0;
      tx_kind_ff  <= KIND_SOF;
      tx_bit_ff   <= 1'b0;
      tx_dual_ff  <= 1'b0;
    end else if (load) begin
      phase_ff    <= nxt_phase;
      idx_ff      <= nxt_idx;
      tx_valid_ff <= (nxt_phase != PH_IDLE);
      tx_kind_ff  <= (nxt_phase == PH_SOF) ? KIND_SOF :
                     (nxt_phase == PH_EOF) ? KIND_EOF : KIND_DATA;
      tx_bit_ff   <= nxt_bit;
      tx_dual_ff  <= (nxt_phase == PH_UID);
    end
  end

  // AXI4-Lite register slave.
  logic       awready_ff, wready_ff, aw_hold_ff, w_hold_ff, bvalid_ff;
  logic       arready_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [1:0] wdata_ff, bresp_ff, rresp_ff;
  logic       wstrb0_ff;
  logic [31:0] rdata_ff;

  wire do_write = aw_hold_ff & w_hold_ff & !bvalid_ff;
  wire wr_ctrl  = (awaddr_ff == REG_CTRL);
  wire [31:0] status_word = {20'h0_0000, 2'(PH_IDLE != phase_ff),
                             boot_done, slot_cnt_ff, round_ff,
                             2'(state_ff), 1'b0, 1'b0};
  wire rd_hit = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_STATUS)
              | (s_axi_araddr == REG_UID_LO) | (s_axi_araddr == REG_UID_HI);
  wire [31:0] rd_word =
    (s_axi_araddr == REG_CTRL)   ? {30'h000_0000, ctrl_ff} :
    (s_axi_araddr == REG_STATUS) ? status_word :
    (s_axi_araddr == REG_UID_LO) ? uid_ff[31:0] :
    (s_axi_araddr == REG_UID_HI) ? {16'h0000, uid_ff[47:32]} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 2'h0;
      wstrb0_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid & awready_ff) begin
        aw_hold_ff <= 1'b1;
        awready_ff <= 1'b0;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & wready_ff) begin
        w_hold_ff <= 1'b1;
        wready_ff <= 1'b0;
        wdata_ff  <= s_axi_wdata[1:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
      end
      if (bvalid_ff & s_axi_bready) begin
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff   <= CTRL_RESET;
      bvalid_ff <= 1'b0;
      bresp_ff  <= AXI_OKAY;
    end else if (do_write) begin
      if (wr_ctrl & wstrb0_ff) ctrl_ff <= wdata_ff;
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_ctrl ? AXI_OKAY : AXI_SLVERR;
    end else if (bvalid_ff & s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= AXI_OKAY;
    end else if (s_axi_arvalid & arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_word;
      rresp_ff   <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (rvalid_ff & s_axi_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  assign tx_valid      = tx_valid_ff;
  assign tx_kind       = tx_kind_ff;
  assign tx_bit        = tx_bit_ff;
  assign tx_dual       = tx_dual_ff;
  assign nvm_rd        = nvm_rd_ff;
  assign nvm_sel       = nvm_sel_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
endmodule

/* logic/rtd_pkg.sv */
// Constants and types shared by the tag command decoder and its CRC unit.
// Assumes the line coder and the memory read port live outside the block.
package rtd_pkg;

  // Request and response field widths.
  localparam int HDR_W  = 11;
  localparam int MLEN_W = 6;
  localparam int UID_W  = 48;
  localparam int AID_W  = 64;
  localparam int CRC_W  = 16;

  // Flag positions inside the 5-bit flag field (bit 0 of the field must be 0).
  localparam int FLG_PROTOCOL_EXT = 0;
  localparam int FLG_INVENTORY    = 1;
  localparam int FLG_RESP_CRC     = 2;
  localparam int FLG_SELECT       = 3;  // reserved_bit when inventory set
  localparam int FLG_ADDRESS      = 4;  // slot_count_flag when inventory set
  localparam int CMD_LSB          = 5;

  // Offsets of frame fields in bit counts.
  localparam logic [7:0] OFS_CMD_END  = 8'h0B;
  localparam logic [7:0] OFS_MASK     = 8'h11;
  localparam logic [7:0] REQ_CRC_BITS = 8'h10;
  localparam logic [7:0] UID_BITS     = 8'h30;

  // Command codes.
  localparam logic [5:0] CMD_INVENTORY   = 6'h00;
  localparam logic [5:0] CMD_GO_QUIET    = 6'h01;
  localparam logic [5:0] CMD_READ_ID     = 6'h02;
  localparam logic [5:0] CMD_INV_ANIMAL  = 6'h23;

  // Mask length limits per slot mode.
  localparam logic [5:0] MLEN_MAX_1SLOT  = 6'h30;
  localparam logic [5:0] MLEN_MAX_16SLOT = 6'h2C;

  // Error reply code and last index of each response field.
  localparam logic [2:0] ERR_CODE      = 3'h7;
  localparam logic [6:0] LAST_UID_IDX  = 7'h2F;
  localparam logic [6:0] LAST_AID_IDX  = 7'h3F;
  localparam logic [6:0] LAST_CODE_IDX = 7'h02;
  localparam logic [6:0] LAST_CRC_IDX  = 7'h0F;
  localparam logic [3:0] LAST_SLOT     = 4'hF;

  // CRC-16 generator settings.
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;

  // Memory read port selects.
  localparam logic NVM_SEL_UID    = 1'b0;
  localparam logic NVM_SEL_ANIMAL = 1'b1;
  localparam logic [2:0] BOOT_DONE = 3'h4;

  // Register map, byte addresses.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_UID_LO = 8'h08;
  localparam logic [7:0] REG_UID_HI = 8'h0C;
  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_REQ_CRC_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_READY, ST_SELECTED, ST_QUIET} rtd_state_t;
  typedef enum logic [2:0] {
    PH_IDLE, PH_SOF, PH_FLAG, PH_UID, PH_ANIMAL, PH_CODE, PH_CRC, PH_EOF
  } rtd_phase_t;
  typedef enum logic [1:0] {KIND_SOF, KIND_DATA, KIND_EOF} rtd_kind_t;

endpackage

/* logic/rtd_crc16.sv */
// Serial CRC-16 register, one bit per enable, in transmission order.
// Assumes the caller clears it before the first bit of each frame.
`timescale 1ns/1ps
module rtd_crc16 (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bit feed
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic        din,
  // Running value
  output logic [15:0]      crc
);
  import rtd_pkg::*;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic        d);
    logic fb;
    fb = c[15] ^ d;
    crc_step = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
  endfunction

  logic [15:0] crc_ff;
  wire  [15:0] nxt_crc = clear ? CRC_PRESET :
                         en    ? crc_step(crc_ff, din) : crc_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_ff <= CRC_PRESET;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

  assign crc = crc_ff;
endmodule

/* dv/rtd_checker.sv */
// Port assertions for the tag command decoder.
// Assumes one clock domain; bound onto every rtd_decoder below.
`timescale 1ns/1ps
module rtd_checker (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // Request end and reply stream
  input wire logic               rx_eof,
  input wire logic               tx_valid,
  input wire rtd_pkg::rtd_kind_t tx_kind,
  input wire logic               tx_bit,
  input wire logic               tx_ready,
  // Memory port
  input wire logic               nvm_rd,
  input wire logic               nvm_sel,
  // Register bus
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid
);
  import rtd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_sof_taken;
    tx_valid && tx_ready && tx_kind == KIND_SOF;
  endsequence
  sequence s_eof_taken;
    tx_valid && tx_ready && tx_kind == KIND_EOF;
  endsequence
  chk_reply_start: assert property (
    $rose(tx_valid) |-> $past(rx_eof) && tx_kind == KIND_SOF)
    else $error("reply began without a preceding end of frame");
  chk_item_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_kind) && $stable(tx_bit))
    else $error("reply item changed before it was taken");
  chk_flag_next: assert property (
    s_sof_taken |=> tx_valid && tx_kind == KIND_DATA)
    else $error("error flag did not follow start of frame");
  chk_eof_last: assert property (
    s_eof_taken |=> !tx_valid)
    else $error("reply continued after end of frame");
  chk_boot_pair: assert property (
    nvm_rd && nvm_sel == NVM_SEL_UID |=> nvm_rd && nvm_sel == NVM_SEL_ANIMAL)
    else $error("memory reads out of order");
  chk_aw_refused: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address accepted");
  chk_b_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_r_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
endmodule
bind rtd_decoder rtd_checker chk (.*);

/* dv/rtd_reader_model.sv */
// Reader side of the reply stream: paces tx_ready and records replies.
// Assumes the bench sends requests itself and reads q and eofs.
`timescale 1ns/1ps
module rtd_reader_model (
  // Clock
  input wire logic               clk,
  // Reply item stream
  input wire logic               tx_valid,
  input wire rtd_pkg::rtd_kind_t tx_kind,
  input wire logic               tx_bit,
  input wire logic               tx_dual,
  output logic                   tx_ready,
  // Pacing
  input wire logic               stall
);
  import rtd_pkg::*;
  // Low bit is the data bit, high bit marks dual-pattern coding.
  logic [1:0] q[$];
  int   eofs = 0;
  initial tx_ready = 1'b0;
  // A slow reader toggles ready so every item is seen held for a cycle.
  always @(posedge clk) begin
    tx_ready <= stall ? !tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      if (tx_kind == KIND_SOF) q = {};
      else if (tx_kind == KIND_DATA) q.push_back({tx_dual, tx_bit});
      else eofs++;
    end
  end
endmodule

/* dv/rtd_decoder_tb.sv */
// Self-checking bench for the tag command decoder.
// Assumes the reader model and a memory answering one cycle after a read.
`timescale 1ns/1ps
module rtd_decoder_tb;
  import rtd_pkg::*;
  typedef struct {
    logic [4:0] f; logic [5:0] c; int nb; logic [47:0] x; int len; logic e;
  } rtd_row_t;
  // Identifier value is arbitrary; low nibble 4 sets the 16-slot reply slot.
  localparam logic [47:0] UID = 48'hA5C3_1E7B_0964;
  localparam logic [63:0] AID = 64'h0F1E_2D3C_4B5A_6978;
  logic clk, rst_n, rx_sof, rx_bit_valid, rx_bit, rx_eof, rx_err, stall;
  logic selected_set, tx_valid, tx_bit, tx_dual, tx_ready, nvm_rd, nvm_sel;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [63:0] nvm_rdata;
  rtd_kind_t tx_kind;
  int err_count = 0;
  int checks = 0;
  rtd_row_t rows[8] = '{
    '{5'h00, CMD_READ_ID, 0, 48'h0000, 49, 1'b0},
    '{5'h04, CMD_READ_ID, 0, 48'h0000, 65, 1'b0},
    '{5'h01, CMD_READ_ID, 0, 48'h0000, 4, 1'b1},
    '{5'h00, 6'h3F, 0, 48'h0000, 0, 1'b0},
    '{5'h12, CMD_INVENTORY, 6, 48'h0000, 49, 1'b0},
    '{5'h12, CMD_INVENTORY, 10, 48'({UID[3:0], 6'h04}), 45, 1'b0},
    '{5'h12, CMD_INV_ANIMAL, 6, 48'h0000, 113, 1'b0},
    '{5'h13, CMD_INVENTORY, 6, 48'h0000, 0, 1'b0}};
  rtd_decoder uut (.*);
  rtd_reader_model rd (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (nvm_rd) nvm_rdata <= nvm_sel ? AID : 64'(UID);
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic pulse_bit(input logic b);
    rx_bit_valid <= 1'b1;
    rx_bit <= b;
    @(posedge clk);
    rx_bit_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic send(logic [4:0] f, logic [5:0] c, int nb, logic [47:0] x);
    logic [63:0] v;
    v = {5'h00, x, c, f};
    rx_sof <= 1'b1;
    @(posedge clk);
    rx_sof <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 11 + nb; i++) pulse_bit(v[i]);
  endtask
  // Silence is only judged after a long quiet window, never by one cycle.
  task automatic close_frame(input int len, input logic e, input int sh,
                             input logic a);
    int e0;
    logic [1:0] want;
    logic [15:0] crc;
    e0 = rd.eofs;
    rx_eof <= 1'b1;
    @(posedge clk);
    rx_eof <= 1'b0;
    for (int i = 0; i < 600 && rd.eofs == e0; i++) @(posedge clk);
    cmp_word(32'(rd.eofs == e0 ? 0 : rd.q.size()), 32'(len));
    for (int i = 0; i < len && i < 49 - sh + (a ? 64 : 0); i++) begin
      want = i > 48 - sh ? 2'(AID[i - 49 + sh]) :
             {!e && i > 0, e | (i > 0 && UID[i - 1 + sh])};
      cmp_word(32'(rd.q[i]), 32'(want));
    end
    // Only the read-identifier reply with the CRC flag is 65 items long.
    if (len == 65) begin
      crc = CRC_PRESET;
      for (int i = 0; i < 49; i++)
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ rd.q[i][0]) ? CRC_POLY : 0);
      for (int i = 0; i < 16; i++)
        cmp_word(32'(rd.q[49 + i]), 32'({1'b0, crc[i]}));
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    // Each channel is released at the edge that takes it.
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (s_axi_awready && !aw_ok) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && !w_ok) s_axi_wvalid <= 1'b0;
      aw_ok = aw_ok | s_axi_awready;
      w_ok = w_ok | s_axi_wready;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    for (int c = 0; c < 40000; c++) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {rx_sof, rx_bit_valid, rx_bit, rx_eof, rx_err, selected_set} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, stall} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = {32'h0000_0000, 4'h1};
    nvm_rdata = 64'h0000_0000_0000_0000;
    do_reset();
    foreach (rows[i]) begin
      send(rows[i].f, rows[i].c, rows[i].nb, rows[i].x);
      close_frame(rows[i].len, rows[i].e, rows[i].nb > 6 ? rows[i].nb - 6 : 0,
                  rows[i].c == CMD_INV_ANIMAL);
    end
    stall <= 1'b1;
    send(5'h02, CMD_INVENTORY, 6, 48'h0000);
    repeat (4) close_frame(0, 1'b0, 0, 1'b0);
    close_frame(49, 1'b0, 0, 1'b0);
    stall <= 1'b0;
    send(5'h00, CMD_GO_QUIET, 0, 48'h0000);
    close_frame(0, 1'b0, 0, 1'b0);
    axi_rd(REG_STATUS, d, r);
    cmp_word(32'(d[3:2]), 32'h0000_0002);
    send(5'h00, CMD_READ_ID, 0, 48'h0000);
    close_frame(0, 1'b0, 0, 1'b0);
    axi_rd(8'h10, d, r);
    cmp_word(32'(r), 32'(AXI_SLVERR));
    axi_wr(REG_STATUS, 32'h0000_0000, r);
    cmp_word(32'(r), 32'(AXI_SLVERR));
    axi_wr(REG_CTRL, 32'h0000_0000, r);
    cmp_word(32'(r), 32'(AXI_OKAY));
    axi_rd(REG_CTRL, d, r);
    cmp_word(d, 32'h0000_0000);
    do_reset();
    axi_rd(REG_CTRL, d, r);
    cmp_word(d, 32'h0000_0001);
    axi_rd(REG_UID_LO, d, r);
    cmp_word(d, UID[31:0]);
    axi_rd(REG_UID_HI, d, r);
    cmp_word(d, {16'h0000, UID[47:32]});
    print_verdict();
  end
endmodule
